// ### bas_pkg.sv
// Package for the boot address select block: constants, codes and carrier types
package bas_pkg;

  localparam int BAS_FIELD_W = 25;
  localparam int BAS_ADDR_W = 32;
  localparam int BAS_CMD_W = 8;
  localparam int BAS_APB_AW = 12;

  // Option field holds address bits [31:7]
  localparam int BAS_FIELD_SHIFT = BAS_ADDR_W - BAS_FIELD_W;

  localparam logic [31:0] BAS_NS_FLASH_LO = 32'h0800_0000;
  localparam logic [31:0] BAS_NS_FLASH_HI = 32'h080F_FFFF;
  localparam logic [31:0] BAS_S_FLASH_LO = 32'h0C00_0000;
  localparam logic [31:0] BAS_S_FLASH_HI = 32'h0C0F_FFFF;
  localparam logic [31:0] BAS_RSS_ADDR = 32'h0FF8_0000;

  // Protection level codes on the readout_protection_level input
  localparam logic [1:0] BAS_RDP_L0 = 2'h0;
  localparam logic [1:0] BAS_RDP_L05 = 2'h1;
  localparam logic [1:0] BAS_RDP_L1 = 2'h2;
  localparam logic [1:0] BAS_RDP_L2 = 2'h3;

  // Register byte offsets
  localparam logic [11:0] BAS_OFS_STATUS = 12'h000;
  localparam logic [11:0] BAS_OFS_ADDR = 12'h004;
  localparam logic [11:0] BAS_OFS_CTRL = 12'h008;
  localparam logic [11:0] BAS_OFS_ENABLE = 12'h00C;

  // Status and control field positions
  localparam int BAS_ST_VALID = 0;
  localparam int BAS_ST_RSS = 1;
  localparam int BAS_ST_FORCED = 2;
  localparam int BAS_ST_SECEN = 3;
  localparam int BAS_ST_LOCK = 4;
  localparam int BAS_ST_STRAP = 5;
  localparam int BAS_ST_RDP = 8;
  localparam int BAS_CTRL_DBGOFF = 0;

  localparam logic [31:0] BAS_ADDR_RST = 32'h0000_0000;
  localparam logic BAS_DBGOFF_RST = 1'b0;

  typedef enum logic [1:0] {PH_WAIT, PH_EVAL, PH_DONE} bas_phase_t;

  typedef struct packed {
    logic [24:0] nonsecure_boot_addr_field_a;
    logic [24:0] nonsecure_boot_addr_field_b;
    logic [24:0] secure_boot_addr_field;
    logic soft_boot_select_bit;
    logic boot_source_select_bit;
    logic security_extension_enable;
    logic boot_lock_bit;
    logic [1:0] readout_protection_level;
    logic [7:0] root_services_cmd;
  } bas_opt_t;

  typedef struct packed {
    logic [31:0] addr;
    logic valid;
    logic root_services_firmware;
    logic forced;
    logic lvl2;
  } bas_result_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } bas_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bas_apb_rsp_t;

endpackage : bas_pkg

// ### bas_boot_select.sv
// Boot address selection with APB status and control registers
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module bas_boot_select
  import bas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic boot_strap_pin,
  input wire bas_opt_t option_word,
  input wire bas_apb_req_t apb_req,
  output bas_apb_rsp_t apb_rsp,
  output logic [31:0] boot_addr,
  output logic boot_valid,
  output logic boot_rss,
  output logic debug_port_enable,
  output logic sram_boot_enable,
  output logic sysmem_boot_enable
);

  typedef struct packed {
    bas_phase_t phase;
    bas_opt_t opt;
    logic strap;
    bas_result_t res;
    logic dbg_off;
    logic [31:0] rdata;
  } bas_state_t;

  bas_state_t st;
  bas_state_t next_st;

  logic eff_sel;
  logic [31:0] raw_addr;
  logic raw_rss;
  logic in_sec;
  logic in_ns;
  logic lvl_restrict;
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] enable_word;

  always_comb begin
    // Effective select: 0 means field a / secure field
    eff_sel = st.opt.boot_source_select_bit ? st.strap
                                            : ~st.opt.soft_boot_select_bit;
    raw_rss = 1'b0;
    if (!st.opt.security_extension_enable) begin
      raw_addr = {eff_sel ? st.opt.nonsecure_boot_addr_field_b
                          : st.opt.nonsecure_boot_addr_field_a,
                  {BAS_FIELD_SHIFT{1'b0}}};
    end else if (st.opt.boot_lock_bit) begin
      raw_addr = {st.opt.secure_boot_addr_field, {BAS_FIELD_SHIFT{1'b0}}};
    end else if (eff_sel || (st.opt.root_services_cmd != '0)) begin
      raw_addr = BAS_RSS_ADDR;
      raw_rss = 1'b1;
    end else begin
      raw_addr = {st.opt.secure_boot_addr_field, {BAS_FIELD_SHIFT{1'b0}}};
    end
    in_sec = ((raw_addr >= BAS_S_FLASH_LO) && (raw_addr <= BAS_S_FLASH_HI))
             || (raw_addr == BAS_RSS_ADDR);
    in_ns = (raw_addr >= BAS_NS_FLASH_LO) && (raw_addr <= BAS_NS_FLASH_HI);
    // Level 0 passes everything; without security only level 2 restricts, so level 0.5 acts as level 0
    lvl_restrict = st.opt.security_extension_enable
                   ? (st.opt.readout_protection_level != BAS_RDP_L0)
                   : (st.opt.readout_protection_level == BAS_RDP_L2);
  end

  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr == BAS_OFS_STATUS) || (apb_req.paddr == BAS_OFS_ADDR)
                  || (apb_req.paddr == BAS_OFS_CTRL) || (apb_req.paddr == BAS_OFS_ENABLE);

  always_comb begin
    status_word = '0;
    status_word[BAS_ST_VALID] = st.res.valid;
    status_word[BAS_ST_RSS] = st.res.root_services_firmware;
    status_word[BAS_ST_FORCED] = st.res.forced;
    status_word[BAS_ST_SECEN] = st.opt.security_extension_enable;
    status_word[BAS_ST_LOCK] = st.opt.boot_lock_bit;
    status_word[BAS_ST_STRAP] = st.strap;
    status_word[BAS_ST_RDP +: 2] = st.opt.readout_protection_level;
    enable_word = '0;
    enable_word[2:0] = {sysmem_boot_enable, sram_boot_enable, debug_port_enable};
  end

  always_comb begin
    next_st = st;
    unique case (st.phase)
      PH_WAIT: begin
        // First edge after reset release catches pin and options
        next_st.opt = option_word;
        next_st.strap = boot_strap_pin;
        next_st.phase = PH_EVAL;
      end
      PH_EVAL: begin
        next_st.res.valid = 1'b1;
        next_st.res.lvl2 = (st.opt.readout_protection_level == BAS_RDP_L2);
        if (lvl_restrict && st.opt.security_extension_enable && !in_sec) begin
          next_st.res.addr = BAS_RSS_ADDR;
          next_st.res.root_services_firmware = 1'b1;
          next_st.res.forced = 1'b1;
        end else if (lvl_restrict && !st.opt.security_extension_enable && !in_ns) begin
          next_st.res.addr = BAS_NS_FLASH_LO;
          next_st.res.root_services_firmware = 1'b0;
          next_st.res.forced = 1'b1;
        end else begin
          next_st.res.addr = raw_addr;
          next_st.res.root_services_firmware = raw_rss;
          next_st.res.forced = 1'b0;
        end
        next_st.phase = PH_DONE;
      end
      PH_DONE: begin
        // Held until the next reset
        next_st.phase = PH_DONE;
      end
    endcase
    if (setup_ph) begin
      unique case (apb_req.paddr)
        BAS_OFS_STATUS: next_st.rdata = status_word;
        BAS_OFS_ADDR: next_st.rdata = st.res.addr;
        BAS_OFS_CTRL: next_st.rdata = {31'h0000_0000, st.dbg_off};
        BAS_OFS_ENABLE: next_st.rdata = enable_word;
        default: next_st.rdata = '0;
      endcase
    end
    if (access_ph && apb_req.pwrite && (apb_req.paddr == BAS_OFS_CTRL)) begin
      next_st.dbg_off = apb_req.pwdata[BAS_CTRL_DBGOFF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{phase: PH_WAIT, opt: '0, strap: 1'b0,
              res: '{addr: BAS_ADDR_RST, valid: 1'b0, root_services_firmware: 1'b0, forced: 1'b0, lvl2: 1'b1},
              dbg_off: BAS_DBGOFF_RST, rdata: '0};
    end else begin
      st <= next_st;
    end
  end

  assign boot_addr = st.res.addr;
  assign boot_valid = st.res.valid;
  assign boot_rss = st.res.root_services_firmware;
  // Until the result is valid everything stays disabled
  assign debug_port_enable = st.res.valid && !st.res.lvl2 && !st.dbg_off;
  assign sram_boot_enable = st.res.valid && !st.res.lvl2;
  assign sysmem_boot_enable = st.res.valid && !st.res.lvl2;

  assign apb_rsp.prdata = st.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access_ph && !mapped;

  default clocking bas_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_VALID_TIMING: assert property (
    (st.phase == PH_WAIT) |=> ##1 boot_valid)
    else $error("boot result not valid two edges after reset release");

  AST_HOLD: assert property (
    boot_valid |=> (boot_valid && $stable(boot_addr) && $stable(boot_rss)))
    else $error("boot result changed after it became valid");

  AST_NOSEC_PIN: assert property (
    ($rose(boot_valid) && !st.opt.security_extension_enable && st.opt.boot_source_select_bit
     && !st.res.forced)
    |-> (boot_addr[31:7] == (st.strap ? st.opt.nonsecure_boot_addr_field_b
                                      : st.opt.nonsecure_boot_addr_field_a)))
    else $error("strap pin did not pick the non-secure field");

  AST_NOSEC_SEL: assert property (
    ($rose(boot_valid) && !st.opt.security_extension_enable && !st.res.forced)
    |-> (boot_addr[31:7] == ((st.opt.boot_source_select_bit ? st.strap
                              : !st.opt.soft_boot_select_bit)
                             ? st.opt.nonsecure_boot_addr_field_b
                             : st.opt.nonsecure_boot_addr_field_a)))
    else $error("non-secure boot field picked wrongly");

  AST_LOCK: assert property (
    ($rose(boot_valid) && st.opt.security_extension_enable && st.opt.boot_lock_bit
     && (st.opt.readout_protection_level == BAS_RDP_L0))
    |-> (boot_addr == {st.opt.secure_boot_addr_field, 7'h00} && !boot_rss))
    else $error("locked boot did not use secure field");

  AST_RSS_SEL: assert property (
    ($rose(boot_valid) && st.opt.security_extension_enable && !st.opt.boot_lock_bit
     && (st.opt.root_services_cmd != 8'h00)) |-> (boot_rss && boot_addr == BAS_RSS_ADDR))
    else $error("root services command did not select root services");

  AST_RSS_ONLY_SEC: assert property (
    boot_rss |-> st.opt.security_extension_enable)
    else $error("root services chosen with security off");

  AST_SEC_RANGE: assert property (
    ($rose(boot_valid) && st.opt.security_extension_enable
     && (st.opt.readout_protection_level != BAS_RDP_L0))
    |-> ((boot_addr >= 32'h0C00_0000 && boot_addr <= 32'h0C0F_FFFF)
         || boot_addr == 32'h0FF8_0000))
    else $error("secure boot address outside allowed window");

  AST_NS_L2_RANGE: assert property (
    ($rose(boot_valid) && !st.opt.security_extension_enable
     && (st.opt.readout_protection_level == BAS_RDP_L2))
    |-> (boot_addr >= 32'h0800_0000 && boot_addr <= 32'h080F_FFFF))
    else $error("level 2 boot address outside flash window");

  AST_L2_DISABLE: assert property (
    (boot_valid && (st.opt.readout_protection_level == BAS_RDP_L2))
    |-> !(debug_port_enable || sram_boot_enable || sysmem_boot_enable))
    else $error("level 2 left a boot or debug path enabled");

  // Selection checks
  AST_NOSEC_SOFT: assert property (
    ($rose(boot_valid) && !st.opt.security_extension_enable && !st.opt.boot_source_select_bit
     && !st.res.forced)
    |-> (boot_addr[31:7] == (st.opt.soft_boot_select_bit ? st.opt.nonsecure_boot_addr_field_a
                                                         : st.opt.nonsecure_boot_addr_field_b)))
    else $error("soft select bit did not pick the non-secure field");

  AST_SEC_FIELD: assert property (
    ($rose(boot_valid) && st.opt.security_extension_enable && !st.opt.boot_lock_bit
     && (st.opt.root_services_cmd == 8'h00) && !st.res.forced
     && !(st.opt.boot_source_select_bit ? st.strap : !st.opt.soft_boot_select_bit))
    |-> ((boot_addr == {st.opt.secure_boot_addr_field, 7'h00}) && !boot_rss))
    else $error("secure boot did not use the secure field");

  AST_RSS_STRAP: assert property (
    ($rose(boot_valid) && st.opt.security_extension_enable && !st.opt.boot_lock_bit
     && (st.opt.boot_source_select_bit ? st.strap : !st.opt.soft_boot_select_bit))
    |-> (boot_rss && (boot_addr == BAS_RSS_ADDR)))
    else $error("select value did not pick root services");

  AST_LOCK_ANY_LEVEL: assert property (
    ($rose(boot_valid) && st.opt.security_extension_enable && st.opt.boot_lock_bit)
    |-> (((boot_addr == {st.opt.secure_boot_addr_field, 7'h00}) && !boot_rss)
         || (st.res.forced && (boot_addr == BAS_RSS_ADDR))))
    else $error("locked boot took another target");

  // Protection level checks, then the check of the boot outputs before the result is valid
  AST_L0_PASS: assert property (
    ($rose(boot_valid) && (st.opt.readout_protection_level == BAS_RDP_L0)) |-> !st.res.forced)
    else $error("level 0 forced a boot address");

  AST_NS_LOW_PASS: assert property (
    ($rose(boot_valid) && !st.opt.security_extension_enable
     && (st.opt.readout_protection_level != BAS_RDP_L2)) |-> !st.res.forced)
    else $error("non-secure boot below level 2 was forced");

  AST_FORCED_NS: assert property (
    ($rose(boot_valid) && st.res.forced && !st.opt.security_extension_enable)
    |-> ((boot_addr == 32'h0800_0000) && !boot_rss))
    else $error("forced non-secure boot not at flash base");

  AST_FORCED_SEC: assert property (
    ($rose(boot_valid) && st.res.forced && st.opt.security_extension_enable)
    |-> ((boot_addr == 32'h0FF8_0000) && boot_rss))
    else $error("forced secure boot not at root services");

  AST_FORCED_CAUSE: assert property (
    ($rose(boot_valid) && st.res.forced)
    |-> (st.opt.readout_protection_level != BAS_RDP_L0))
    else $error("address forced at level 0");

  AST_PRE_VALID_ADDR: assert property (
    (!boot_valid) |-> ((boot_addr == BAS_ADDR_RST) && !boot_rss))
    else $error("boot outputs moved before the result was valid");

  // Enable and register checks
  AST_ENABLES_OFF: assert property (
    (!boot_valid) |-> !(debug_port_enable || sram_boot_enable || sysmem_boot_enable))
    else $error("path enabled before the result was valid");

  AST_ENABLES_ON: assert property (
    (boot_valid && (st.opt.readout_protection_level != BAS_RDP_L2))
    |-> (sram_boot_enable && sysmem_boot_enable))
    else $error("boot paths disabled below level 2");

  AST_DBG_CTRL: assert property (
    (boot_valid && !st.res.lvl2) |-> (debug_port_enable == !st.dbg_off))
    else $error("debug enable does not follow the control bit");

  AST_LVL2_FLAG: assert property (
    $rose(boot_valid) |-> (st.res.lvl2 == (st.opt.readout_protection_level == BAS_RDP_L2)))
    else $error("level 2 flag wrong at result time");

  AST_CTRL_WRITE: assert property (
    (access_ph && apb_req.pwrite && (apb_req.paddr == BAS_OFS_CTRL))
    |=> (st.dbg_off == $past(apb_req.pwdata[BAS_CTRL_DBGOFF])))
    else $error("control write did not land");

  AST_WRITE_IGNORED: assert property (
    (access_ph && apb_req.pwrite && (apb_req.paddr != BAS_OFS_CTRL)) |=> $stable(st.dbg_off))
    else $error("write to another offset changed the control bit");

  AST_INPUTS_HELD: assert property (
    (st.phase == PH_DONE) |=> ($stable(st.strap) && $stable(st.opt)))
    else $error("captured inputs changed after the result");

  AST_DONE_STAYS: assert property (
    (st.phase != PH_WAIT) |=> (st.phase != PH_WAIT))
    else $error("selection ran again without reset");

  AST_SLVERR_IDLE: assert property (
    (!access_ph) |-> !apb_rsp.pslverr)
    else $error("error response outside an access phase");

  AST_READ_ADDR: assert property (
    (setup_ph && (apb_req.paddr == BAS_OFS_ADDR)) |=> (apb_rsp.prdata == $past(boot_addr)))
    else $error("address register read wrong");

  AST_READ_STATUS: assert property (
    (setup_ph && (apb_req.paddr == BAS_OFS_STATUS))
    |=> (apb_rsp.prdata[BAS_ST_VALID] == $past(boot_valid)))
    else $error("status valid bit read wrong");

  AST_READ_CTRL: assert property (
    (setup_ph && (apb_req.paddr == BAS_OFS_CTRL))
    |=> (apb_rsp.prdata == {31'h0000_0000, $past(st.dbg_off)}))
    else $error("control register read wrong");

  AST_UNMAPPED_ZERO: assert property (
    (setup_ph && !mapped) |=> (apb_rsp.prdata == 32'h0000_0000))
    else $error("unmapped read returned data");

endmodule : bas_boot_select

`default_nettype wire

// ### bas_board_model.sv
// Board model: option storage and boot strap jumper feeding the boot selector
`timescale 1ns/100ps
`default_nettype none

module bas_board_model
  import bas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire bas_opt_t opt_in,
  input wire logic pin_in,
  output bas_opt_t option_word,
  output logic boot_strap_pin
);
  logic [3:0] age;

  assign option_word = opt_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end

  // Jumper is moved to the other level once the boot choice is made
  assign boot_strap_pin = (age < 4'h3) ? pin_in : ~pin_in;
endmodule : bas_board_model

`default_nettype wire

// ### boot_address_select_tb.sv
// Testbench for the boot address selector: boot cases and register access
`timescale 1ns/100ps
`default_nettype none

module boot_address_select_tb;
  import bas_pkg::*;
  localparam logic [24:0] FA = 25'h010_0000;
  localparam logic [24:0] FB = 25'h017_F100;
  localparam logic [24:0] FS = 25'h018_0000;
  localparam logic [24:0] FR = 25'h040_0000;
  localparam logic [24:0] FE = 25'h010_1FFF;
  logic pclk;
  logic presetn;
  logic pin;
  logic sp;
  bas_opt_t opt;
  bas_opt_t ow;
  bas_apb_req_t req;
  bas_apb_rsp_t rsp;
  logic [31:0] baddr;
  logic bval, brss, den, sen, men, er;
  logic [31:0] rd;
  int mismatches, cmp_count;

  bas_board_model bas_board_model_inst (.pclk(pclk), .presetn(presetn), .opt_in(opt),
    .pin_in(pin), .option_word(ow), .boot_strap_pin(sp));
  bas_boot_select bas_boot_select_inst (.pclk(pclk), .presetn(presetn),
    .boot_strap_pin(sp), .option_word(ow), .apb_req(req), .apb_rsp(rsp),
    .boot_addr(baddr), .boot_valid(bval), .boot_rss(brss), .debug_port_enable(den),
    .sram_boot_enable(sen), .sysmem_boot_enable(men));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // f holds {security, lock, source, soft bit, pin}; rf holds {rss, forced}
  task automatic run(input logic [4:0] f, input logic [7:0] c, input logic [1:0] l,
                     input logic [24:0] fa, input logic [24:0] fs, input logic [31:0] ea,
                     input logic [1:0] rf);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    opt <= '{fa, FB, fs, f[1], f[2], f[4], f[3], l, c};
    pin <= f[0];
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bval !== 1'b1 && n < 10);
    repeat (6) @(posedge pclk);
    check(baddr, ea);
    check({30'h0, brss, bval}, {30'h0, rf[1], 1'b1});
    check({29'h0, den, sen, men}, {29'h0, {3{l != BAS_RDP_L2}}});
    apb(1'b0, BAS_OFS_STATUS, 32'h0000_0000);
    check(rd & 32'h0000_033F, {22'h0, l, 2'b00, f[0], f[3], f[4], rf[0], rf[1], 1'b1});
    apb(1'b0, BAS_OFS_ADDR, 32'h0000_0000);
    check(rd, ea);
    $display("Test done: boot address %h", ea);
  endtask : run

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    pin = 1'b0;
    opt = '0;
    req = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    run(5'b00100, 8'h00, BAS_RDP_L0, FA, FS, 32'h0800_0000, 2'b00);
    run(5'b00101, 8'h00, BAS_RDP_L0, FA, FS, 32'h0BF8_8000, 2'b00);
    run(5'b00011, 8'h00, BAS_RDP_L0, FA, FS, 32'h0800_0000, 2'b00);
    run(5'b00000, 8'h00, BAS_RDP_L0, FA, FS, 32'h0BF8_8000, 2'b00);
    run(5'b10100, 8'h00, BAS_RDP_L0, FA, FS, 32'h0C00_0000, 2'b00);
    run(5'b10101, 8'h00, BAS_RDP_L0, FA, FS, 32'h0FF8_0000, 2'b10);
    run(5'b10000, 8'h00, BAS_RDP_L0, FA, FS, 32'h0FF8_0000, 2'b10);
    run(5'b10010, 8'h05, BAS_RDP_L0, FA, FS, 32'h0FF8_0000, 2'b10);
    run(5'b11001, 8'h05, BAS_RDP_L0, FA, FS, 32'h0C00_0000, 2'b00);
    run(5'b00101, 8'h05, BAS_RDP_L0, FA, FS, 32'h0BF8_8000, 2'b00);
    run(5'b00100, 8'h00, BAS_RDP_L2, FR, FS, 32'h0800_0000, 2'b01);
    run(5'b00100, 8'h00, BAS_RDP_L2, FE, FS, 32'h080F_FF80, 2'b00);
    run(5'b00100, 8'h00, BAS_RDP_L1, FR, FS, 32'h2000_0000, 2'b00);
    run(5'b10100, 8'h00, BAS_RDP_L05, FA, FR, 32'h0FF8_0000, 2'b11);
    run(5'b10100, 8'h00, BAS_RDP_L0, FA, FR, 32'h2000_0000, 2'b00);
    apb(1'b1, BAS_OFS_CTRL, 32'h0000_0001);
    apb(1'b0, BAS_OFS_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    check({31'h0, den}, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001);
    $display("Test done: register access");
    print_verdict();
  end
endmodule : boot_address_select_tb

`default_nettype wire
